/* core/ctw_params.svh */
// Opcodes, flag positions, reset values and cycle counts for the test/transfer/wait decoder
`ifndef CTW_PARAMS_SVH
`define CTW_PARAMS_SVH

// ==============================================
// Opcodes
`define CTW_OP_TEST_DIR  8'h3d
`define CTW_OP_TEST_ACC  8'h4d
`define CTW_OP_TEST_IDX  8'h5d
`define CTW_OP_TEST_SOFS 8'h6d
`define CTW_OP_TEST_XPTR 8'h7d
`define CTW_OP_TEST_LOFS 8'hdd
`define CTW_OP_COPY_XA  8'h9f
`define CTW_OP_WAIT     8'h8f

// ==============================================
// Condition code bit positions
`define CTW_CC_C 0
`define CTW_CC_Z 1
`define CTW_CC_N 2
`define CTW_CC_I 3
`define CTW_CC_H 4

// ==============================================
// Reset values
`define CTW_CC_RESET   8'he8
`define CTW_ACC_RESET  8'h00
`define CTW_IDX_RESET  8'h00
`define CTW_PC_RESET   16'h0000

// ==============================================
// Cycle counts per instruction
`define CTW_CYC_TEST_DIR  4
`define CTW_CYC_TEST_ACC  3
`define CTW_CYC_TEST_IDX  3
`define CTW_CYC_TEST_SOFS 5
`define CTW_CYC_TEST_XPTR 4
`define CTW_CYC_TEST_LOFS 5
`define CTW_CYC_COPY_XA 2
`define CTW_CYC_WAIT    2
`define CTW_CYC_OTHER   2

`endif

/* core/ctw_pkg.sv */
// Types for the test/transfer/wait decoder
package ctw_pkg;

    // ==============================================
    // Sequencer states
    typedef enum logic [6:0] {
        S_FETCH = 7'b0000001,
        S_OFSH  = 7'b0000010,
        S_OFSL  = 7'b0000100,
        S_READ  = 7'b0001000,
        S_EXEC  = 7'b0010000,
        S_PAD   = 7'b0100000,
        S_WAIT  = 7'b1000000
    } ctw_state_t;

    // ==============================================
    // Operand source of a test
    typedef enum logic [1:0] {
        SRC_MEM = 2'b00,
        SRC_ACC = 2'b01,
        SRC_IDX = 2'b10
    } ctw_src_t;

endpackage

/* core/ctw_decoder.sv */
// Decoder and sequencer for test, index-to-accumulator copy and wait
//
// Contract
// - Test operand against zero, update N, Z only
// - Opcode 9F copies index to accumulator
// - Opcode 8F clears I, halts core clock
// - Short indexed: one offset byte plus index
// - Long indexed: high then low offset plus index
`timescale 1ns/1ps
`include "ctw_params.svh"

module ctw_decoder #(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Program memory
    output logic [15:0]      memAddr,
    output logic             memRead,
    input  wire logic [7:0]  memData,
    // Wake-up
    input  wire logic        irqReq,
    // Core state
    output logic [7:0]       accOut,
    output logic [7:0]       idxOut,
    output logic [7:0]       ccOut,
    output logic [15:0]      pcOut,
    output logic             clkHalted,
    output logic             instrDone,
    output logic             badOpcode
);

    // ==============================================
    // State
    ctw_pkg::ctw_state_t state_r;
    ctw_pkg::ctw_src_t   src_r;
    logic [7:0]          opcode_r;
    logic [7:0]          acc_r;
    logic [7:0]          idx_r;
    logic [7:0]          cc_r;
    logic [15:0]         pc_r;
    logic [15:0]         ea_r;
    logic [7:0]          ofsHi_r;
    logic [CNT_W-1:0]    cnt_r;
    logic [CNT_W-1:0]    cycTotal_r;
    logic                done_r;
    logic                bad_r;

    // ==============================================
    // Decode of a fresh opcode
    logic [CNT_W-1:0]    cycNew;
    logic                isOffset1;
    logic                isOffset2;
    logic                isMemNoOfs;
    logic                isDirect;
    logic                known;
    logic [7:0]          testVal;

    always_comb begin
        cycNew     = CNT_W'(`CTW_CYC_OTHER);
        isOffset1  = 1'b0;
        isOffset2  = 1'b0;
        isMemNoOfs = 1'b0;
        isDirect   = 1'b0;
        known      = 1'b1;
        case (memData)
            `CTW_OP_TEST_DIR: begin
                cycNew   = CNT_W'(`CTW_CYC_TEST_DIR);
                isDirect = 1'b1;
            end
            `CTW_OP_TEST_ACC: cycNew = CNT_W'(`CTW_CYC_TEST_ACC);
            `CTW_OP_TEST_IDX: cycNew = CNT_W'(`CTW_CYC_TEST_IDX);
            `CTW_OP_TEST_SOFS: begin
                cycNew    = CNT_W'(`CTW_CYC_TEST_SOFS);
                isOffset1 = 1'b1;
            end
            `CTW_OP_TEST_XPTR: begin
                cycNew     = CNT_W'(`CTW_CYC_TEST_XPTR);
                isMemNoOfs = 1'b1;
            end
            `CTW_OP_TEST_LOFS: begin
                cycNew    = CNT_W'(`CTW_CYC_TEST_LOFS);
                isOffset2 = 1'b1;
            end
            `CTW_OP_COPY_XA: cycNew = CNT_W'(`CTW_CYC_COPY_XA);
            `CTW_OP_WAIT:    cycNew = CNT_W'(`CTW_CYC_WAIT);
            default:         known = 1'b0;
        endcase
    end

    always_comb begin
        case (src_r)
            ctw_pkg::SRC_ACC: testVal = acc_r;
            ctw_pkg::SRC_IDX: testVal = idx_r;
            default:          testVal = memData;
        endcase
    end

    // ==============================================
    // Memory port
    always_comb begin
        memRead = 1'b0;
        memAddr = pc_r;
        case (state_r)
            ctw_pkg::S_FETCH: memRead = 1'b1;
            ctw_pkg::S_OFSH:  memRead = 1'b1;
            ctw_pkg::S_OFSL:  memRead = 1'b1;
            ctw_pkg::S_READ: begin
                memRead = 1'b1;
                memAddr = ea_r;
            end
            default: memRead = 1'b0;
        endcase
    end

    // ==============================================
    // Sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ctw_pkg::S_FETCH;
            src_r      <= ctw_pkg::SRC_MEM;
            opcode_r   <= 8'h00;
            pc_r       <= `CTW_PC_RESET;
            ea_r       <= 16'h0000;
            ofsHi_r    <= 8'h00;
            cnt_r      <= '0;
            cycTotal_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
            case (state_r)
                ctw_pkg::S_FETCH: begin
                    opcode_r   <= memData;
                    pc_r       <= pc_r + 16'h0001;
                    cnt_r      <= CNT_W'(1);
                    cycTotal_r <= cycNew;
                    src_r      <= ctw_pkg::SRC_MEM;
                    if (memData == `CTW_OP_TEST_ACC) begin
                        src_r <= ctw_pkg::SRC_ACC;
                    end
                    if (memData == `CTW_OP_TEST_IDX) begin
                        src_r <= ctw_pkg::SRC_IDX;
                    end
                    if (isOffset2) begin
                        state_r <= ctw_pkg::S_OFSH;
                    end else if (isOffset1 || isDirect) begin
                        state_r <= ctw_pkg::S_OFSL;
                    end else if (isMemNoOfs) begin
                        ea_r    <= {8'h00, idx_r};
                        state_r <= ctw_pkg::S_READ;
                    end else if (!known) begin
                        state_r <= ctw_pkg::S_PAD;
                    end else begin
                        state_r <= ctw_pkg::S_EXEC;
                    end
                end
                ctw_pkg::S_OFSH: begin
                    ofsHi_r <= memData;
                    pc_r    <= pc_r + 16'h0001;
                    state_r <= ctw_pkg::S_OFSL;
                end
                ctw_pkg::S_OFSL: begin
                    pc_r    <= pc_r + 16'h0001;
                    state_r <= ctw_pkg::S_READ;
                    if (opcode_r == `CTW_OP_TEST_DIR) begin
                        ea_r <= {8'h00, memData};
                    end else if (opcode_r == `CTW_OP_TEST_LOFS) begin
                        ea_r <= {ofsHi_r, memData} + {8'h00, idx_r};
                    end else begin
                        ea_r <= {8'h00, memData} + {8'h00, idx_r};
                    end
                end
                ctw_pkg::S_READ: state_r <= ctw_pkg::S_EXEC;
                ctw_pkg::S_EXEC: begin
                    if (opcode_r == `CTW_OP_WAIT) begin
                        state_r <= ctw_pkg::S_WAIT;
                    end else if (cnt_r + CNT_W'(1) >= cycTotal_r) begin
                        state_r <= ctw_pkg::S_FETCH;
                    end else begin
                        state_r <= ctw_pkg::S_PAD;
                    end
                end
                ctw_pkg::S_PAD: begin
                    if (cnt_r + CNT_W'(1) >= cycTotal_r) begin
                        state_r <= ctw_pkg::S_FETCH;
                    end
                end
                ctw_pkg::S_WAIT: begin
                    // Held here; only an unmasked request leaves, registers untouched
                    if (irqReq && !cc_r[`CTW_CC_I]) begin
                        state_r <= ctw_pkg::S_FETCH;
                    end
                end
                default: state_r <= ctw_pkg::S_FETCH;
            endcase
        end
    end

    // ==============================================
    // Accumulator and index
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r <= `CTW_ACC_RESET;
            idx_r <= `CTW_IDX_RESET;
        end else if (state_r == ctw_pkg::S_EXEC && opcode_r == `CTW_OP_COPY_XA) begin
            acc_r <= idx_r;
        end
    end

    // ==============================================
    // Condition codes; copy leaves them alone
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cc_r <= `CTW_CC_RESET;
        end else if (state_r == ctw_pkg::S_READ) begin
            cc_r[`CTW_CC_N] <= memData[7];
            cc_r[`CTW_CC_Z] <= (memData == 8'h00);
        end else if (state_r == ctw_pkg::S_EXEC) begin
            if (opcode_r == `CTW_OP_TEST_ACC || opcode_r == `CTW_OP_TEST_IDX) begin
                cc_r[`CTW_CC_N] <= testVal[7];
                cc_r[`CTW_CC_Z] <= (testVal == 8'h00);
            end else if (opcode_r == `CTW_OP_WAIT) begin
                cc_r[`CTW_CC_I] <= 1'b0;
            end
        end
    end

    // ==============================================
    // Status strobes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            done_r <= 1'b0;
            bad_r  <= 1'b0;
        end else begin
            done_r <= (state_r != ctw_pkg::S_FETCH) && (state_r != ctw_pkg::S_WAIT)
                      && (state_r != ctw_pkg::S_OFSH) && (state_r != ctw_pkg::S_OFSL)
                      && (state_r != ctw_pkg::S_READ)
                      && !(state_r == ctw_pkg::S_EXEC && opcode_r == `CTW_OP_WAIT)
                      && (cnt_r + CNT_W'(1) >= cycTotal_r);
            bad_r  <= (state_r == ctw_pkg::S_FETCH) && !known;
        end
    end

    assign accOut    = acc_r;
    assign idxOut    = idx_r;
    assign ccOut     = cc_r;
    assign pcOut     = pc_r;
    assign clkHalted = (state_r == ctw_pkg::S_WAIT);
    assign instrDone = done_r;
    assign badOpcode = bad_r;

endmodule

/* tb/ctw_decoder_properties.sv */
// Port checks for the test/transfer/wait decoder
`timescale 1ns/1ps
module ctw_decoder_properties (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset_n,
    // Program memory
    input wire logic [15:0] memAddr,
    input wire logic        memRead,
    input wire logic [7:0]  memData,
    // Wake-up
    input wire logic        irqReq,
    // Core state
    input wire logic [7:0]  accOut,
    input wire logic [7:0]  idxOut,
    input wire logic [7:0]  ccOut,
    input wire logic [15:0] pcOut,
    input wire logic        clkHalted,
    input wire logic        instrDone,
    input wire logic        badOpcode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ==============================================
    // Flags
    AST_CH_KEPT: assert property ($stable({ccOut[4], ccOut[0]}))
        else $error("carry or half carry moved");
    AST_NZ_EXCL: assert property (!(ccOut[1] && ccOut[2]))
        else $error("zero and negative both set");
    AST_MASK_NO_SET: assert property (!$rose(ccOut[3]))
        else $error("interrupt mask set");
    AST_HALT_MASK: assert property ($rose(clkHalted) |-> !ccOut[3])
        else $error("halted with mask set");
    // ==============================================
    // Registers and wait
    AST_ACC_SRC: assert property ($changed(accOut) |-> accOut == idxOut)
        else $error("accumulator not from index");
    AST_DONE_GAP: assert property (instrDone |=> !instrDone)
        else $error("done pulses adjacent");
    AST_WAIT_HOLD: assert property (clkHalted && !irqReq |=>
        clkHalted && $stable(accOut) && $stable(pcOut) && $stable(ccOut))
        else $error("state moved in wait");
    AST_WAKE: assert property (clkHalted && irqReq && !ccOut[3] |=> !clkHalted)
        else $error("no wake on request");
    AST_IDX_KEPT: assert property ($stable(idxOut))
        else $error("index register moved");
    COV_HALT: cover property ($rose(clkHalted));
    COV_ZERO: cover property ($rose(ccOut[1]));
    COV_NEG: cover property ($rose(ccOut[2]));
endmodule

bind ctw_decoder ctw_decoder_properties u_props (.ref_clk, .reset_n, .memAddr, .memRead,
    .memData, .irqReq, .accOut, .idxOut, .ccOut, .pcOut, .clkHalted, .instrDone, .badOpcode);

/* tb/ctw_mem_model.sv */
// Program memory answering reads in the same cycle
`timescale 1ns/1ps
module ctw_mem_model (
    // Bus
    input wire logic [15:0] memAddr,
    input wire logic        memRead,
    output logic [7:0]      memData
);
    logic [7:0] bytes [0:511];
    // Unread cycles show inverted data, never a usable byte
    always_comb begin
        memData = memRead ? bytes[memAddr[8:0]] : ~bytes[memAddr[8:0]];
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the test/transfer/wait decoder
`timescale 1ns/1ps
module testbench;
    logic        ref_clk;
    logic        reset_n;
    logic [15:0] memAddr;
    logic        memRead;
    logic [7:0]  memData;
    logic        irqReq;
    logic [7:0]  accOut;
    logic [7:0]  idxOut;
    logic [7:0]  ccOut;
    logic [15:0] pcOut;
    logic        clkHalted;
    logic        instrDone;
    logic        badOpcode;
    int          fail_count;
    int          samples_checked;
    int          seed;
    int          badSeen;
    int          badSent;
    int          doneSeen;
    int          doneQ [$];
    int          pc;
    logic [7:0]  expCc;
    logic [7:0]  expAcc;
    // Index is never written by this core
    localparam logic [7:0] IDX = 8'h00;
    logic [7:0]  ops [9] = '{8'h3d, 8'h4d, 8'h5d, 8'h6d, 8'h7d, 8'hdd, 8'h9f, 8'h9d, 8'h8f};
    int          cyc [9] = '{4, 3, 3, 5, 4, 5, 2, 2, 2};
    int          len [9] = '{2, 1, 1, 2, 1, 3, 1, 1, 1};

    ctw_decoder DUT (.ref_clk, .reset_n, .memAddr, .memRead, .memData, .irqReq, .accOut,
        .idxOut, .ccOut, .pcOut, .clkHalted, .instrDone, .badOpcode);
    ctw_mem_model mem (.memAddr, .memRead, .memData);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) if (badOpcode === 1'b1) badSeen++;
    always @(posedge ref_clk) if (instrDone === 1'b1) doneSeen++;

    // ==============================================
    // Compare and report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checked=%0d failed=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==============================================
    // Place one instruction, run it to the next fetch (to the halt for wait), compare
    task automatic run(input int k);
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] v;
        int         ea;
        op = ops[k];
        b1 = 8'($random(seed));
        b2 = 8'($random(seed) & 1);
        mem.bytes[pc] = op;
        mem.bytes[pc+1] = (op == 8'hdd) ? b2 : b1;
        mem.bytes[pc+2] = (op == 8'hdd) ? b1 : b2;
        case (op)
            8'h3d: ea = b1;
            8'h6d: ea = b1 + IDX;
            8'h7d: ea = IDX;
            8'hdd: ea = {b2, b1} + IDX;
            default: ea = -1;
        endcase
        v = (ea >= 0) ? mem.bytes[ea] : ((op == 8'h4d) ? expAcc : IDX);
        if (op[3:0] == 4'hd && op != 8'h9d) expCc[2:1] = {v[7], v == 8'h00};
        if (op == 8'h9f) expAcc = IDX;
        if (op == 8'h8f) expCc[3] = 1'b0;
        if (op == 8'h9d) badSent++;
        if (op != 8'h8f) doneQ.push_back(k);
        repeat (cyc[k]) @(posedge ref_clk);
        @(negedge ref_clk);
        pc += len[k];
        check(pcOut, pc[15:0]);
        check(16'(ccOut), 16'(expCc));
        check(16'(accOut), 16'(expAcc));
        check(16'(instrDone), 16'(k != 8));
        if (k == 8) check(16'(clkHalted), 16'h0001);
    endtask

    initial begin
        seed = 5;
        reset_n = 1'b0;
        irqReq = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        badSeen = 0;
        badSent = 0;
        doneSeen = 0;
        for (int a = 0; a < 512; a++) mem.bytes[a] = 8'($random(seed));
        repeat (20) @(negedge ref_clk);
        check({accOut, idxOut}, 16'h0000);
        check(16'(ccOut), 16'h00e8);
        reset_n = 1'b1;
        pc = 0;
        expCc = 8'he8;
        expAcc = 8'h00;
        for (int i = 0; i < 60; i++) run(($random(seed) & 32'h7fffffff) % 8);
        run(8);
        repeat (5) @(negedge ref_clk);
        check(16'(clkHalted), 16'h0001);
        check(pcOut, pc[15:0]);
        irqReq = 1'b1;
        @(negedge ref_clk);
        irqReq = 1'b0;
        check(16'(clkHalted), 16'h0000);
        for (int k = 3; k < 7; k++) run(k);
        run(8);
        reset_n = 1'b0;
        @(negedge ref_clk);
        check(16'(clkHalted), 16'h0000);
        check(pcOut, 16'h0000);
        check(16'(badSeen), 16'(badSent));
        check(16'(doneSeen), 16'(doneQ.size()));
        tally_and_finish;
    end

    // Hang guard, well beyond the expected few hundred cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish;
    end
endmodule
